// file: hw/reload_timer_consts.svh
`ifndef RELOAD_TIMER_CONSTS_SVH
`define RELOAD_TIMER_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TMR_OFF_CTRL 8'h00
`define TMR_OFF_OSHOT 8'h04
`define TMR_OFF_IOC 8'h08
`define TMR_OFF_MODE 8'h0C
`define TMR_OFF_PRE 8'h10
`define TMR_OFF_SEC 8'h14
`define TMR_OFF_PRI 8'h18

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TMR_CTRL_START 0
`define TMR_CTRL_STATUS 1
`define TMR_CTRL_FSTOP 2
`define TMR_OS_START 0
`define TMR_OS_STOP 1
`define TMR_OS_STATUS 2
`define TMR_IOC_POL 0
`define TMR_IOC_TRIG_EN 1
`define TMR_IOC_PORT_DIR 2
`define TMR_IOC_PORT_DATA 3
`define TMR_MODE_LSB 0
`define TMR_SRC_LSB 4

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define TMR_RST_COUNT 8'hFF
`define TMR_RST_IOC 4'h0
`define TMR_SRC_DIV2 3'h1
`define TMR_SRC_DIV8 3'h7

`endif

// file: hw/reload_timer_pkg.sv
package reload_timer_pkg;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_WAVE = 2'h1,
    MODE_ONESHOT = 2'h2,
    MODE_WAIT = 2'h3
  } timer_mode_t;

  typedef enum logic [1:0] {
    PH_PRIMARY = 2'h1,
    PH_SECONDARY = 2'h2
  } phase_t;

endpackage

// file: hw/trigger_sync.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"

module trigger_sync (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out
);

  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic level_r;
  logic level_nxt;
  logic rise_r;
  logic rise_nxt;

  // change counts once stages two and three agree
  always_comb
  begin
    sync_nxt = {sync_r[1:0], pin_in};
    level_nxt = level_r;
    rise_nxt = 1'b0;
    if (sync_r[1] == sync_r[2])
    begin
      level_nxt = sync_r[2];
      rise_nxt = sync_r[2] & ~level_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sync_r <= 3'h0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
    end
    else
    begin
      sync_r <= sync_nxt;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign level_out = level_r;
  assign rise_out = rise_r;

endmodule

// file: hw/count_source_gen.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"

module count_source_gen (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic [1:0] sel_in,
  output logic tick_out
);

  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic tick_r;
  logic tick_nxt;

  // sel 0: every clock, 1: every 2nd, others: every 8th
  always_comb
  begin
    div_nxt = div_r + 3'h1;
    unique case (sel_in)
      2'h0: tick_nxt = 1'b1;
      2'h1: tick_nxt = ((div_r & `TMR_SRC_DIV2) == `TMR_SRC_DIV2);
      default: tick_nxt = (div_r == `TMR_SRC_DIV8);
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      div_r <= 3'h0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

endmodule

// file: hw/reload_timer.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"

module reload_timer (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic external_trigger_input_in,
  output logic timer_pulse_output_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic tick, trig_rise;
  logic [1:0] src_sel_r, src_sel_nxt;

  count_source_gen u_src (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .sel_in(src_sel_r),
    .tick_out(tick)
  );

  trigger_sync u_trig (
    .ref_clk_in(ref_clk_in),
    .resetn_in(resetn_in),
    .pin_in(external_trigger_input_in),
    .level_out(),
    .rise_out(trig_rise)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reload_timer_pkg::timer_mode_t mode_r, mode_nxt;
  reload_timer_pkg::phase_t phase_r, phase_nxt;
  logic start_r, start_nxt;
  logic start_seen_r, start_seen_nxt;
  logic status_r, status_nxt;
  logic os_flag_r, os_flag_nxt;
  logic os_pend_r, os_pend_nxt;
  logic os_want_r, os_want_nxt;
  logic os_age_r, os_age_nxt;
  logic [3:0] ioc_r, ioc_nxt;
  logic [7:0] pre_rl_r, pre_rl_nxt;
  logic [7:0] sec_rl_r, sec_rl_nxt;
  logic [7:0] pri_rl_r, pri_rl_nxt;
  logic [7:0] pre_cnt_r, pre_cnt_nxt;
  logic [7:0] pri_cnt_r, pri_cnt_nxt;
  logic out_r, out_nxt;
  logic dph_wr_r, dph_wr_nxt;
  logic [7:0] dph_addr_r, dph_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic hreadyout_r, hresp_r;

  logic addr_ok, accept;
  logic wr_ctrl, wr_os, wr_ioc, wr_mode, wr_pre, wr_sec, wr_pri;
  logic [7:0] wbyte;
  logic one_shot_mode, running, wave_level;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  always_comb
  begin
    accept = hsel_in & hready_in & htrans_in[1];
    addr_ok = (haddr_in[31:8] == 24'h000000) & (haddr_in[1:0] == 2'h0);
    wbyte = hwdata_in[7:0];
    wr_ctrl = dph_wr_r & (dph_addr_r == `TMR_OFF_CTRL);
    wr_os = dph_wr_r & (dph_addr_r == `TMR_OFF_OSHOT);
    wr_ioc = dph_wr_r & (dph_addr_r == `TMR_OFF_IOC);
    wr_mode = dph_wr_r & (dph_addr_r == `TMR_OFF_MODE);
    wr_pre = dph_wr_r & (dph_addr_r == `TMR_OFF_PRE);
    wr_sec = dph_wr_r & (dph_addr_r == `TMR_OFF_SEC);
    wr_pri = dph_wr_r & (dph_addr_r == `TMR_OFF_PRI);
    dph_wr_nxt = accept & hwrite_in & addr_ok;
    dph_addr_nxt = haddr_in[7:0];
  end

  // output level before the polarity bit
  always_comb
  begin
    unique case (mode_r)
      reload_timer_pkg::MODE_WAVE: wave_level = (phase_r == reload_timer_pkg::PH_PRIMARY);
      reload_timer_pkg::MODE_ONESHOT: wave_level = os_flag_r & status_r;
      reload_timer_pkg::MODE_WAIT:
        wave_level = os_flag_r & status_r & (phase_r == reload_timer_pkg::PH_SECONDARY);
      default: wave_level = 1'b0;
    endcase
  end

  // reads see the live counters byte by byte
  always_comb
  begin
    hrdata_nxt = hrdata_r;
    if (accept)
    begin
      hrdata_nxt = 32'h00000000;
      if (!hwrite_in && addr_ok)
      begin
        unique case (haddr_in[7:0])
          `TMR_OFF_CTRL: hrdata_nxt[2:0] = {1'b0, status_r, start_r};
          `TMR_OFF_OSHOT: hrdata_nxt[2:0] = {os_flag_r, 2'h0};
          `TMR_OFF_IOC:
          begin
            hrdata_nxt[2:0] = ioc_r[2:0];
            hrdata_nxt[`TMR_IOC_PORT_DATA] = ioc_r[`TMR_IOC_PORT_DIR] ?
              ioc_r[`TMR_IOC_PORT_DATA] : out_r;
          end
          `TMR_OFF_MODE: hrdata_nxt[5:0] = {src_sel_r, 2'h0, mode_r};
          `TMR_OFF_PRE: hrdata_nxt[7:0] = pre_cnt_r;
          `TMR_OFF_SEC: hrdata_nxt[7:0] = sec_rl_r;
          `TMR_OFF_PRI: hrdata_nxt[7:0] = pri_cnt_r;
          default: hrdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // counting core
  // ---------------------------------------------------------------
  always_comb
  begin
    one_shot_mode = (mode_r == reload_timer_pkg::MODE_ONESHOT) |
                    (mode_r == reload_timer_pkg::MODE_WAIT);
    running = status_r & (~one_shot_mode | os_flag_r);
    src_sel_nxt = src_sel_r;
    mode_nxt = mode_r;
    phase_nxt = phase_r;
    start_nxt = start_r;
    start_seen_nxt = start_seen_r;
    status_nxt = status_r;
    os_flag_nxt = os_flag_r;
    os_pend_nxt = os_pend_r;
    os_want_nxt = os_want_r;
    os_age_nxt = os_age_r;
    ioc_nxt = ioc_r;
    pre_rl_nxt = pre_rl_r;
    sec_rl_nxt = sec_rl_r;
    pri_rl_nxt = pri_rl_r;
    pre_cnt_nxt = pre_cnt_r;
    pri_cnt_nxt = pri_cnt_r;

    // start bit passes two count source stages
    if (tick)
    begin
      start_seen_nxt = start_r;
      status_nxt = start_seen_r;
    end

    // count on each tick while running
    if (tick && running)
    begin
      if (pre_cnt_r != 8'h00)
        pre_cnt_nxt = pre_cnt_r - 8'h01;
      else
      begin
        pre_cnt_nxt = pre_rl_r;
        if (pri_cnt_r != 8'h00)
          pri_cnt_nxt = pri_cnt_r - 8'h01;
        else
        begin
          unique case (mode_r)
            reload_timer_pkg::MODE_TIMER: pri_cnt_nxt = pri_rl_r;
            reload_timer_pkg::MODE_WAVE:
            begin
              if (phase_r == reload_timer_pkg::PH_PRIMARY)
              begin
                phase_nxt = reload_timer_pkg::PH_SECONDARY;
                pri_cnt_nxt = sec_rl_r;
              end
              else
              begin
                phase_nxt = reload_timer_pkg::PH_PRIMARY;
                pri_cnt_nxt = pri_rl_r;
              end
            end
            reload_timer_pkg::MODE_ONESHOT:
            begin
              os_flag_nxt = 1'b0;
              pri_cnt_nxt = pri_rl_r;
            end
            default:
            begin
              if (phase_r == reload_timer_pkg::PH_PRIMARY)
              begin
                phase_nxt = reload_timer_pkg::PH_SECONDARY;
                pri_cnt_nxt = sec_rl_r;
              end
              else
              begin
                phase_nxt = reload_timer_pkg::PH_PRIMARY;
                os_flag_nxt = 1'b0;
                pri_cnt_nxt = pri_rl_r;
              end
            end
          endcase
        end
      end
    end

    // one-shot request settles on the second tick after it is raised
    if (tick && os_pend_r)
    begin
      if (!os_age_r)
        os_age_nxt = 1'b1;
      else
      begin
        os_pend_nxt = 1'b0;
        os_flag_nxt = os_want_r;
        if (!os_want_r && one_shot_mode)
        begin
          pre_cnt_nxt = pre_rl_r;
          pri_cnt_nxt = pri_rl_r;
          phase_nxt = reload_timer_pkg::PH_PRIMARY;
        end
      end
    end

    // external trigger acts as a one-shot start
    if (trig_rise && ioc_r[`TMR_IOC_TRIG_EN] && one_shot_mode && status_r && !os_flag_r &&
        !os_pend_r)
    begin
      os_pend_nxt = 1'b1;
      os_want_nxt = 1'b1;
      os_age_nxt = 1'b0;
    end

    // start clear in one-shot modes reloads then stops
    if (status_r && !status_nxt && one_shot_mode)
    begin
      pre_cnt_nxt = pre_rl_r;
      pri_cnt_nxt = pri_rl_r;
      phase_nxt = reload_timer_pkg::PH_PRIMARY;
      os_flag_nxt = 1'b0;
      os_pend_nxt = 1'b0;
    end

    // register writes: counter too while stopped, reload only while running
    if (wr_pre)
    begin
      pre_rl_nxt = wbyte;
      if (!running)
        pre_cnt_nxt = wbyte;
    end
    if (wr_sec)
      sec_rl_nxt = wbyte;
    if (wr_pri)
    begin
      pri_rl_nxt = wbyte;
      if (!running)
        pri_cnt_nxt = wbyte;
    end
    if (wr_ioc)
      ioc_nxt = wbyte[3:0];
    if (wr_mode)
    begin
      mode_nxt = reload_timer_pkg::timer_mode_t'(wbyte[1:0]);
      src_sel_nxt = wbyte[5:4];
    end
    // later write wins when start and stop race
    if (wr_os && (wbyte[`TMR_OS_START] || wbyte[`TMR_OS_STOP]))
    begin
      os_pend_nxt = 1'b1;
      os_want_nxt = ~wbyte[`TMR_OS_STOP];
      os_age_nxt = 1'b0;
    end
    if (wr_ctrl)
    begin
      start_nxt = wbyte[`TMR_CTRL_START];
      if (wbyte[`TMR_CTRL_FSTOP])
      begin
        // halt at once, no synchroniser delay
        start_nxt = 1'b0;
        start_seen_nxt = 1'b0;
        status_nxt = 1'b0;
        os_flag_nxt = 1'b0;
        os_pend_nxt = 1'b0;
        if (mode_r == reload_timer_pkg::MODE_WAVE && phase_r == reload_timer_pkg::PH_PRIMARY)
        begin
          pre_rl_nxt = `TMR_RST_COUNT;
          pre_cnt_nxt = `TMR_RST_COUNT;
          pri_rl_nxt = `TMR_RST_COUNT;
          pri_cnt_nxt = `TMR_RST_COUNT;
        end
        phase_nxt = reload_timer_pkg::PH_PRIMARY;
      end
    end
    out_nxt = wave_level ^ ioc_r[`TMR_IOC_POL];
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      src_sel_r <= 2'h0;
      mode_r <= reload_timer_pkg::MODE_TIMER;
      phase_r <= reload_timer_pkg::PH_PRIMARY;
      start_r <= 1'b0;
      start_seen_r <= 1'b0;
      status_r <= 1'b0;
      os_flag_r <= 1'b0;
      os_pend_r <= 1'b0;
      os_want_r <= 1'b0;
      os_age_r <= 1'b0;
      ioc_r <= `TMR_RST_IOC;
      pre_rl_r <= `TMR_RST_COUNT;
      sec_rl_r <= `TMR_RST_COUNT;
      pri_rl_r <= `TMR_RST_COUNT;
      pre_cnt_r <= `TMR_RST_COUNT;
      pri_cnt_r <= `TMR_RST_COUNT;
      out_r <= 1'b0;
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else
    begin
      src_sel_r <= src_sel_nxt;
      mode_r <= mode_nxt;
      phase_r <= phase_nxt;
      start_r <= start_nxt;
      start_seen_r <= start_seen_nxt;
      status_r <= status_nxt;
      os_flag_r <= os_flag_nxt;
      os_pend_r <= os_pend_nxt;
      os_want_r <= os_want_nxt;
      os_age_r <= os_age_nxt;
      ioc_r <= ioc_nxt;
      pre_rl_r <= pre_rl_nxt;
      sec_rl_r <= sec_rl_nxt;
      pri_rl_r <= pri_rl_nxt;
      pre_cnt_r <= pre_cnt_nxt;
      pri_cnt_r <= pri_cnt_nxt;
      out_r <= out_nxt;
      dph_wr_r <= dph_wr_nxt;
      dph_addr_r <= dph_addr_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  assign hrdata_out = hrdata_r;
  assign hreadyout_out = hreadyout_r;
  assign hresp_out = hresp_r;
  assign timer_pulse_output_out = out_r;

endmodule

// file: dv/reload_timer_chk.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"

module reload_timer_chk (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic external_trigger_input_in,
  input wire logic timer_pulse_output_out
);
  logic dp_valid_r;
  logic dp_valid_nxt;
  logic dp_write_r;
  logic [31:0] dp_addr_r;
  logic stopped_r;
  logic stopped_nxt;
  logic cfg_r;
  logic cfg_nxt;
  logic rd_stop_r;
  logic is_ctrl;
  logic is_ioc;
  logic is_os;
  logic map_ok;
  logic wr_land;

  // ---------------------------------------------------------------
  // data phase tracking
  // ---------------------------------------------------------------
  always_comb
  begin
    dp_valid_nxt = hsel_in & hready_in & htrans_in[1];
    is_ctrl = dp_addr_r == {24'h0, `TMR_OFF_CTRL};
    is_ioc = dp_addr_r == {24'h0, `TMR_OFF_IOC};
    is_os = dp_addr_r == {24'h0, `TMR_OFF_OSHOT};
    map_ok = dp_addr_r[31:8] == 24'h0 && dp_addr_r[1:0] == 2'h0 && dp_addr_r[7:0] <= 8'h18;
    wr_land = dp_valid_r & dp_write_r & hready_in;
    stopped_nxt = stopped_r;
    cfg_nxt = cfg_r;
    if (wr_land && is_ctrl && hwdata_in[`TMR_CTRL_START])
      stopped_nxt = 1'b0;
    else if (wr_land && is_ctrl && hwdata_in[`TMR_CTRL_FSTOP])
      stopped_nxt = 1'b1;
    if (wr_land && (is_ctrl || is_ioc || is_os))
      cfg_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r <= 32'h0;
      stopped_r <= 1'b1;
      cfg_r <= 1'b0;
      rd_stop_r <= 1'b1;
    end
    else
    begin
      dp_valid_r <= dp_valid_nxt;
      dp_write_r <= hwrite_in;
      dp_addr_r <= haddr_in;
      stopped_r <= stopped_nxt;
      cfg_r <= cfg_nxt;
      rd_stop_r <= stopped_r;
    end
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence rd_ctrl_s;
    dp_valid_r && !dp_write_r && is_ctrl;
  endsequence

  sequence rd_ioc_s;
    dp_valid_r && !dp_write_r && is_ioc;
  endsequence

  chk_ready_high: assert property (hreadyout_out)
    else $error("bus ready dropped");
  chk_resp_okay: assert property (!hresp_out)
    else $error("bus response not okay");
  chk_rdata_stands: assert property (!dp_valid_r |-> $stable(hrdata_out))
    else $error("read data moved without a transfer");
  chk_unmapped_zero: assert property (dp_valid_r && !dp_write_r && !map_ok |-> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_stop_reads_zero: assert property (rd_ctrl_s |-> !hrdata_out[`TMR_CTRL_FSTOP])
    else $error("forced stop bit read as one");
  chk_stopped_idle: assert property (rd_ctrl_s ##0 rd_stop_r |-> hrdata_out[1:0] == 2'h0)
    else $error("status set while stopped");
  chk_pulse_idle: assert property (!cfg_r |-> !timer_pulse_output_out)
    else $error("pulse output active before setup");
  chk_port_readback: assert property (rd_ioc_s ##0 !hrdata_out[`TMR_IOC_PORT_DIR]
    |-> hrdata_out[`TMR_IOC_PORT_DATA] == $past(timer_pulse_output_out))
    else $error("port data read differs from output");
endmodule

bind reload_timer reload_timer_chk reload_timer_chk_i (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
  .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .external_trigger_input_in(external_trigger_input_in),
  .timer_pulse_output_out(timer_pulse_output_out)
);

// file: dv/reload_timer_tb.sv
`timescale 1ns/1ps
`include "reload_timer_consts.svh"

module reload_timer_tb;
  logic clk;
  logic resetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic trig;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic pulse;
  logic [31:0] rd;
  int error_cnt;
  int total_checks;
  int n;
  int k;
  // address, write flag, write data, expected read
  logic [31:0] rows [17] = '{32'h10_00_00_FF, 32'h14_00_00_FF, 32'h18_00_00_FF,
    32'h00_00_00_00, 32'h04_00_00_00, 32'h08_00_00_00, 32'h0C_00_00_00, 32'h1C_00_00_00,
    32'h10_01_12_12, 32'h14_01_34_34, 32'h18_01_56_56, 32'h08_01_0E_0E, 32'h08_01_00_00,
    32'h00_01_04_00, 32'h1C_01_AA_00, 32'h0C_01_21_21, 32'h0C_01_00_00};

  reload_timer reload_timer_i (
    .ref_clk_in(clk), .resetn_in(resetn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .external_trigger_input_in(trig), .timer_pulse_output_out(pulse)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chkb(input string nm, input logic c);
    chk(nm, {31'h0, c}, 32'h1);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  // repeated reads until a bit reaches the wanted level
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    n = 0;
    do
    begin
      bus(1'b0, a, 32'h0);
      n++;
    end
    while (rd[b] !== v && n < 40);
    chk("poll_bit", {31'h0, rd[b]}, {31'h0, v});
  endtask

  task automatic wait_pulse();
    k = 0;
    while (pulse !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trig = 1'b0;
    error_cnt = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i][16])
        bus(1'b1, rows[i][31:24], {24'h0, rows[i][15:8]});
      rdc("reg_row", rows[i][31:24], {24'h0, rows[i][7:0]});
    end
    $display("register table test done");
    // timer mode, source divided by eight, values loaded while stopped
    bus(1'b1, `TMR_OFF_MODE, 32'h20);
    bus(1'b1, `TMR_OFF_PRE, 32'h0);
    bus(1'b1, `TMR_OFF_PRI, 32'h80);
    bus(1'b1, `TMR_OFF_CTRL, 32'h1);
    poll(`TMR_OFF_CTRL, 1, 1'b1);
    chkb("start_delay", n >= 2 && n <= 7);
    repeat (20) @(posedge clk);
    bus(1'b0, `TMR_OFF_PRI, 32'h0);
    chkb("count_live", rd[7:0] != 8'h80);
    // writes while counting go to the reload value only
    bus(1'b1, `TMR_OFF_PRE, 32'h0);
    repeat (24) @(posedge clk);
    bus(1'b1, `TMR_OFF_PRI, 32'hF0);
    bus(1'b0, `TMR_OFF_PRI, 32'h0);
    chkb("run_reload_only", rd[7:0] < 8'h80);
    bus(1'b1, `TMR_OFF_CTRL, 32'h0);
    poll(`TMR_OFF_CTRL, 1, 1'b0);
    chkb("stop_delay", n >= 2 && n <= 7);
    bus(1'b1, `TMR_OFF_CTRL, 32'h1);
    poll(`TMR_OFF_CTRL, 1, 1'b1);
    bus(1'b1, `TMR_OFF_CTRL, 32'h4);
    rdc("forced_stop", `TMR_OFF_CTRL, 32'h0);
    $display("start stop test done");
    // waveform mode stopped by force in its primary period
    bus(1'b1, `TMR_OFF_MODE, 32'h21);
    bus(1'b1, `TMR_OFF_PRE, 32'h3);
    bus(1'b1, `TMR_OFF_SEC, 32'h2);
    bus(1'b1, `TMR_OFF_PRI, 32'h5);
    bus(1'b1, `TMR_OFF_CTRL, 32'h1);
    poll(`TMR_OFF_CTRL, 1, 1'b1);
    wait_pulse();
    chkb("wave_primary", pulse === 1'b1);
    bus(1'b1, `TMR_OFF_CTRL, 32'h4);
    rdc("wave_pre", `TMR_OFF_PRE, 32'hFF);
    rdc("wave_pri", `TMR_OFF_PRI, 32'hFF);
    $display("waveform test done");
    // one-shot: start, read pin through port, stop reloads
    bus(1'b1, `TMR_OFF_MODE, 32'h12);
    bus(1'b1, `TMR_OFF_PRE, 32'h1);
    bus(1'b1, `TMR_OFF_PRI, 32'h40);
    bus(1'b1, `TMR_OFF_CTRL, 32'h1);
    poll(`TMR_OFF_CTRL, 1, 1'b1);
    bus(1'b1, `TMR_OFF_OSHOT, 32'h1);
    poll(`TMR_OFF_OSHOT, 2, 1'b1);
    chkb("os_start", rd[2] === 1'b1 && n <= 7);
    bus(1'b0, `TMR_OFF_IOC, 32'h0);
    chkb("port_read", rd[3] === 1'b1);
    bus(1'b1, `TMR_OFF_OSHOT, 32'h2);
    poll(`TMR_OFF_OSHOT, 2, 1'b0);
    chkb("os_stop", rd[2] === 1'b0 && n <= 7);
    rdc("os_pri", `TMR_OFF_PRI, 32'h40);
    rdc("os_pre", `TMR_OFF_PRE, 32'h1);
    bus(1'b1, `TMR_OFF_CTRL, 32'h4);
    $display("one-shot test done");
    // wait one-shot started from the trigger pin
    bus(1'b1, `TMR_OFF_MODE, 32'h23);
    bus(1'b1, `TMR_OFF_IOC, 32'h2);
    bus(1'b1, `TMR_OFF_SEC, 32'h2);
    bus(1'b1, `TMR_OFF_PRI, 32'h3);
    bus(1'b1, `TMR_OFF_CTRL, 32'h1);
    poll(`TMR_OFF_CTRL, 1, 1'b1);
    repeat (8) @(posedge clk);
    trig <= 1'b1;
    poll(`TMR_OFF_OSHOT, 2, 1'b1);
    chkb("trig_start", rd[2] === 1'b1);
    wait_pulse();
    chkb("wait_pulse", pulse === 1'b1);
    poll(`TMR_OFF_OSHOT, 2, 1'b0);
    chkb("wait_end", rd[2] === 1'b0);
    trig <= 1'b0;
    // wait one-shot started by software
    bus(1'b1, `TMR_OFF_SEC, 32'h2);
    bus(1'b1, `TMR_OFF_PRI, 32'h3);
    repeat (8) @(posedge clk);
    bus(1'b1, `TMR_OFF_OSHOT, 32'h1);
    poll(`TMR_OFF_OSHOT, 2, 1'b1);
    wait_pulse();
    chkb("sw_wait_pulse", pulse === 1'b1);
    poll(`TMR_OFF_OSHOT, 2, 1'b0);
    rdc("sw_wait_pri", `TMR_OFF_PRI, 32'h3);
    $display("wait one-shot test done");
    // reset in mid-run
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdc("rst_ctrl", `TMR_OFF_CTRL, 32'h0);
    rdc("rst_pri", `TMR_OFF_PRI, 32'hFF);
    $display("reset test done");
    end_of_test();
  end
endmodule
